// File: esm_pkg.sv
/*
 * Constants and carrier types of the error status monitor: serial command
 * addresses, frame layout, status bit positions and reset values.
 * Assumes nothing of its surroundings; imported whole by the monitor.
 */
package esm_pkg;

    // Serial frame layout
    localparam int unsigned FRAME_BITS   = 16;
    localparam logic [4:0]  FRAME_CNT    = 5'h10;
    localparam int unsigned RW_BIT       = 15;

    // Serial register map, command addresses
    localparam logic [13:0] ADDR_NOP         = 14'h0000;
    localparam logic [13:0] ADDR_POR_OFF     = 14'h3f22;
    localparam logic [13:0] ADDR_SOFT_RESET  = 14'h3c00;
    localparam logic [13:0] ADDR_MASTER_RST  = 14'h33a5;
    localparam logic [13:0] ADDR_CLEAR_ERR   = 14'h3380;
    localparam logic [13:0] ADDR_GAIN_CTRL   = 14'h3ff8;
    localparam logic [13:0] ADDR_ANGLE       = 14'h3fff;
    localparam logic [13:0] ADDR_ERR_STATUS  = 14'h335a;
    localparam logic [13:0] ADDR_SYS_CONFIG  = 14'h3f20;

    // Error status register fields
    localparam int unsigned BIT_PARITY       = 0;
    localparam int unsigned BIT_CLK_COUNT    = 1;
    localparam int unsigned BIT_BAD_ADDR     = 2;
    localparam int unsigned BIT_MEAS_BUSY    = 4;
    localparam int unsigned DSP_LSB          = 8;
    localparam int unsigned DSP_WIDTH        = 6;
    localparam int unsigned STATUS_WIDTH     = 14;

    // Reset values
    localparam logic [2:0]  PIN_RST          = 3'h1;
    localparam logic [15:0] TX_RST           = 16'h0000;
    localparam logic [4:0]  CNT_RST          = 5'h00;

    // Raw serial pin bundle, asynchronous to clk
    typedef struct packed {
        logic sck;
        logic mosi;
        logic ss_n;
    } esm_spi_in_s;

    // Sticky communication error flags
    typedef struct packed {
        logic bad_address_flag;
        logic clock_count_error_flag;
        logic parity_error_flag;
    } esm_err_s;

    // Source of the word returned in the next frame
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_ANGLE,
        SEL_STATUS
    } esm_sel_e;

endpackage

// File: esm_error_status_monitor.sv
/*
 * Error status monitor with its serial slave link: receives 16-bit command
 * frames, checks clock count, parity and address, keeps the sticky link
 * error flags and the measurement-in-progress flag, and returns the
 * addressed word in the following frame.
 * Assumes the serial pins are asynchronous to clk and the link clock is at
 * most a sixteenth of clk; the measurement core answers on clk.
 */
// How it works
// [R1] The measurement-in-progress flag (bit 4) is one while an angle read is processed.
// [R2] The flag returns to zero when the measurement core reports completion.
// [R3] A stuck flag only comes from a deadlock, and a full-chip reset command releases it.
// [R4] A host seeing the flag stay high sends the full-chip reset command to recover.
// [R5] A valid frame naming an address outside the map sets the bad-address flag (bit 2).
// [R6] A frame without exactly sixteen clocks sets the clock-count error flag (bit 1).
// [R7] A sixteen-clock frame whose even parity fails sets the parity error flag (bit 0).
// [R8] Bits 3, 5, 6 and 7 of the status word always read zero and cannot be written.
// [R9] A set link error flag stays set until the clear-error or full-chip reset command runs.
// [R10] The status word is read at command address 0x335A.
// [R11] The host sends no angle read while the measurement flag is high.
// [R12] Both alarm bits of the angle word are one on a major error or while measuring.
`timescale 1ns/1ns

module esm_error_status_monitor
    import esm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    // Serial pins
    input  wire esm_spi_in_s       spi_in,
    output logic                   miso_o,
    output logic                   miso_oe,
    // Measurement core
    output logic                   meas_start_o,
    input  wire logic              meas_done_i,
    input  wire logic [11:0]       angle_i,
    input  wire logic              field_strong_alarm_i,
    input  wire logic              field_weak_alarm_i,
    input  wire logic              major_err_i,
    input  wire logic [5:0]        dsp_err_i,
    // Chip control and status
    output logic                   chip_reset_o,
    output logic                   meas_busy_o,
    output esm_err_s               err_flags_o
);

    logic [2:0]        s1_ff;
    logic [2:0]        s2_ff;
    logic [2:0]        s3_ff;
    logic [2:0]        pin_ff;
    logic [2:0]        prev_ff;
    logic [15:0]       rx_ff;
    logic [15:0]       tx_ff;
    logic [4:0]        cnt_ff;
    logic              busy_ff;
    esm_err_s          err_ff;
    esm_sel_e          sel_ff;
    logic              start_ff;
    logic              reset_ff;
    logic              oe_ff;

    logic              ss_fall;
    logic              ss_rise;
    logic              sck_rise;
    logic              sck_fall;
    logic [13:0]       addr;
    logic              len_ok;
    logic              par_ok;
    logic              known;
    logic              exec;
    logic              any_err;
    logic              alarm_both;
    logic [13:0]       status_word;
    logic [13:0]       tx_data;
    logic [15:0]       nxt_tx;
    esm_err_s          err_set;
    logic              err_clr;

    // Three-stage pin capture; a level counts once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1_ff   <= PIN_RST;
            s2_ff   <= PIN_RST;
            s3_ff   <= PIN_RST;
            pin_ff  <= PIN_RST;
            prev_ff <= PIN_RST;
        end
        else if (ce)
        begin
            s1_ff   <= {spi_in.sck, spi_in.mosi, spi_in.ss_n};
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            pin_ff  <= (s2_ff & s3_ff) | (pin_ff & (s2_ff ^ s3_ff));
            prev_ff <= pin_ff;
        end
    end

    assign ss_fall  = prev_ff[0] & ~pin_ff[0];
    assign ss_rise  = ~prev_ff[0] & pin_ff[0];
    assign sck_rise = ~prev_ff[2] & pin_ff[2] & ~pin_ff[0];
    assign sck_fall = prev_ff[2] & ~pin_ff[2] & ~pin_ff[0];

    // Frame checks at slave-select release
    assign addr    = rx_ff[14:1];
    assign len_ok  = (cnt_ff == FRAME_CNT);
    assign par_ok  = ~(^rx_ff);
    assign known   = (addr == ADDR_NOP) || (addr == ADDR_POR_OFF)
                  || (addr == ADDR_SOFT_RESET) || (addr == ADDR_MASTER_RST)
                  || (addr == ADDR_CLEAR_ERR) || (addr == ADDR_GAIN_CTRL)
                  || (addr == ADDR_ANGLE) || (addr == ADDR_ERR_STATUS)
                  || (addr == ADDR_SYS_CONFIG);
    assign exec    = ss_rise & len_ok & par_ok & known;

    always_comb
    begin
        err_set.clock_count_error_flag = ss_rise & ~len_ok;          // [R6]
        err_set.parity_error_flag      = ss_rise & len_ok & ~par_ok; // [R7]
        err_set.bad_address_flag       = ss_rise & len_ok & par_ok & ~known; // [R5]
    end

    assign err_clr = exec & ((addr == ADDR_CLEAR_ERR) || (addr == ADDR_MASTER_RST));

    // Receive shift on falling link clock, counts saturate above one frame
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rx_ff  <= TX_RST;
            cnt_ff <= CNT_RST;
        end
        else if (ce)
        begin
            if (ss_fall)
            begin
                rx_ff  <= TX_RST;
                cnt_ff <= CNT_RST;
            end
            else if (sck_fall)
            begin
                rx_ff <= {rx_ff[14:0], pin_ff[1]};
                if (cnt_ff <= FRAME_CNT)
                    cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end

    // Sticky link errors; a new error wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (!nrst)
            err_ff <= '0;
        else if (ce)
            err_ff <= (err_ff & ~{3{err_clr}}) | err_set; // [R9]
    end

    // Measurement-in-progress flag
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            busy_ff  <= 1'b0;
            start_ff <= 1'b0;
            reset_ff <= 1'b0;
        end
        else if (ce)
        begin
            start_ff <= 1'b0;
            reset_ff <= 1'b0;
            if (exec && addr == ADDR_MASTER_RST)
            begin
                busy_ff  <= 1'b0;                                    // [R3]
                reset_ff <= 1'b1;                                    // [R3]
            end
            else if (exec && rx_ff[RW_BIT] && addr == ADDR_ANGLE && !busy_ff) // [R11]
            begin
                busy_ff  <= 1'b1;                                    // [R1]
                start_ff <= 1'b1;
            end
            else if (meas_done_i)
                busy_ff <= 1'b0;                                     // [R2]
        end
    end

    // Word returned in the next frame
    always_ff @(posedge clk)
    begin
        if (!nrst)
            sel_ff <= SEL_NONE;
        else if (ce && ss_rise)
        begin
            if (!exec)
                sel_ff <= SEL_NONE;
            else if (addr == ADDR_ANGLE)
                sel_ff <= SEL_ANGLE;
            else if (addr == ADDR_ERR_STATUS || addr == ADDR_CLEAR_ERR) // [R10]
                sel_ff <= SEL_STATUS;
            else
                sel_ff <= SEL_NONE;
        end
    end

    assign any_err    = |err_ff;
    assign alarm_both = major_err_i | busy_ff;
    assign status_word = {dsp_err_i, 3'h0, busy_ff, 1'b0, err_ff.bad_address_flag,
                          err_ff.clock_count_error_flag,
                          err_ff.parity_error_flag};                 // [R8]

    always_comb
    begin
        case (sel_ff)
            SEL_ANGLE:
                tx_data = {field_weak_alarm_i | alarm_both,
                           field_strong_alarm_i | alarm_both, angle_i}; // [R12]
            SEL_STATUS:
                tx_data = status_word;
            default:
                tx_data = 14'h0000;
        endcase
        nxt_tx = {tx_data, any_err, ^{tx_data, any_err}};
    end

    // Transmit: first bit at select, next bit on each rising link clock after the first
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tx_ff <= TX_RST;
            oe_ff <= 1'b0;
        end
        else if (ce)
        begin
            oe_ff <= ~pin_ff[0];
            if (ss_fall)
                tx_ff <= nxt_tx;
            else if (sck_rise && cnt_ff != CNT_RST)
                tx_ff <= {tx_ff[14:0], 1'b0};
        end
    end

    assign miso_o       = tx_ff[15];
    assign miso_oe      = oe_ff;
    assign meas_start_o = start_ff;
    assign chip_reset_o = reset_ff;
    assign meas_busy_o  = busy_ff;
    assign err_flags_o  = err_ff;

endmodule

// File: esm_monitor_sva.sv
/* Port checker of the error status monitor.
   Assumes the select pin moves only between frames. */
`timescale 1ns/1ns
module esm_monitor_sva
    import esm_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // Watched ports
    input wire esm_spi_in_s spi_in,
    input wire logic        miso_oe,
    input wire logic        meas_start_o,
    input wire logic        meas_done_i,
    input wire logic        chip_reset_o,
    input wire logic        meas_busy_o,
    input wire esm_err_s    err_flags_o
);
    logic [4:0] hi_ff;
    logic [4:0] lo_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles the select pin has stayed high or low, saturating
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            hi_ff <= 5'h00;
            lo_ff <= 5'h00;
        end
        else
        begin
            hi_ff <= !spi_in.ss_n ? 5'h00 : hi_ff + {4'h0, hi_ff != 5'h1f};
            lo_ff <= spi_in.ss_n ? 5'h00 : lo_ff + {4'h0, lo_ff != 5'h1f};
        end
    end
    a_start_busy: assert property (meas_start_o |-> ##[0:1] meas_busy_o)
        else $error("busy not set");
    a_start_gate: assert property (meas_start_o |-> !$past(meas_busy_o, 3))
        else $error("start while busy");
    a_cmd_time: assert property ((meas_start_o || chip_reset_o) |-> hi_ff inside {[3:10]})
        else $error("command pulse off frame end");
    a_busy_fall: assert property ($fell(meas_busy_o) && !$past(meas_done_i) && !$past(meas_done_i, 2) |-> ##[0:1] chip_reset_o)
        else $error("busy fell without cause");
    a_reset_clear: assert property (chip_reset_o |-> !meas_busy_o && err_flags_o == 3'h0)
        else $error("full reset left state");
    a_flags_quiet: assert property (hi_ff >= 5'h0c |-> $stable(err_flags_o))
        else $error("flags moved outside frame");
    a_oe_frame: assert property (lo_ff >= 5'h08 |-> miso_oe)
        else $error("miso not driven in frame");
    a_oe_idle: assert property (hi_ff >= 5'h08 |-> !miso_oe)
        else $error("miso driven while idle");
endmodule
bind esm_error_status_monitor esm_monitor_sva i_esm_monitor_sva (.clk, .nrst, .spi_in,
    .miso_oe, .meas_start_o, .meas_done_i, .chip_reset_o, .meas_busy_o, .err_flags_o);

// File: esm_host_model.sv
/* Serial master model: one frame per call, link clock 160 ns.
   Assumes a 100 MHz clk; answer bits taken at falling sck. */
`timescale 1ns/1ns
module esm_host_model
    import esm_pkg::*;
(
    // Clock
    input wire logic    clk,
    // Serial pins
    output esm_spi_in_s spi_in,
    input wire logic    miso_o,
    input wire logic    miso_oe
);
    initial spi_in = '{sck: 1'b0, mosi: 1'b0, ss_n: 1'b1};
    task automatic half();
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk);
        #1 spi_in.ss_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            half();
            spi_in.sck = 1'b1;
            spi_in.mosi = (i < 16) ? w[15 - i] : 1'b0;
            half();
            if (i < 16)
                r[15 - i] = miso_oe ? miso_o : 1'bx;
            spi_in.sck = 1'b0;
        end
        half();
        spi_in.ss_n = 1'b1;
        // Released data line shows the inverse of its last level
        spi_in.mosi = ~spi_in.mosi;
        half();
    endtask
endmodule

// File: testbench.sv
/* Self-checking bench of the error status monitor.
   Assumes package, design, host model and checker compiled first. */
`timescale 1ns/1ns
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module testbench
    import esm_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        meas_done_i = 1'b0;
    logic        ce = 1'b1;
    logic        major_err_i = 1'b0;
    logic [5:0]  dsp_err_i = 6'h2a;
    esm_spi_in_s spi_in;
    logic        miso_o;
    logic        miso_oe;
    logic        meas_start_o;
    logic        chip_reset_o;
    logic        meas_busy_o;
    esm_err_s    err_flags_o;
    logic [15:0] rx;
    int          n_errors = 0;
    int          check_count = 0;
    int          n_start = 0;
    int          n_chip = 0;
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        if (meas_start_o === 1'b1) n_start++;
        if (chip_reset_o === 1'b1) n_chip++;
    end
    esm_error_status_monitor i_esm_error_status_monitor (.clk, .nrst, .ce, .spi_in,
        .miso_o, .miso_oe, .meas_start_o, .meas_done_i, .angle_i(12'h5a5),
        .field_strong_alarm_i(1'b1), .field_weak_alarm_i(1'b0), .major_err_i,
        .dsp_err_i, .chip_reset_o, .meas_busy_o, .err_flags_o);
    esm_host_model i_esm_host_model (.clk, .spi_in, .miso_o, .miso_oe);
    function automatic logic [15:0] cw(input logic rw, input logic [13:0] a);
        return {rw, a, ^{rw, a}};
    endfunction
    function automatic logic [15:0] aw(input logic [13:0] d, input logic ef);
        return {d, ef, ^{d, ef}};
    endfunction
    function automatic logic [13:0] st(input logic b, input logic [2:0] f);
        return {dsp_err_i, 3'h0, b, 1'b0, f};
    endfunction
    task automatic frame(input logic [15:0] w, input int n, input logic [15:0] exp);
        i_esm_host_model.xfer(w, n, rx);
        `CHK("answer", rx, exp)
    endtask
    task automatic t_status();
        frame(cw(1'b1, ADDR_ERR_STATUS), 16, 16'h0000);
        frame(cw(1'b0, ADDR_ERR_STATUS), 16, aw(st(1'b0, 3'h0), 1'b0));
        frame(cw(1'b0, ADDR_NOP), 16, aw(st(1'b0, 3'h0), 1'b0));
        // The ADDR_POR_OFF, ADDR_SOFT_RESET, ADDR_GAIN_CTRL and ADDR_SYS_CONFIG commands are accepted without an address error
        frame(cw(1'b1, ADDR_POR_OFF), 16, 16'h0000);
        frame(cw(1'b1, ADDR_SOFT_RESET), 16, 16'h0000);
        frame(cw(1'b0, ADDR_GAIN_CTRL), 16, 16'h0000);
        frame(cw(1'b1, ADDR_SYS_CONFIG), 16, 16'h0000);
        `CHK("mapped", err_flags_o, 3'h0)
    endtask
    task automatic t_errors();
        logic [15:0] w;
        int          n;
        logic [2:0]  f;
        dsp_err_i = 6'h15;
        for (int k = 0; k < 4; k++)
        begin
            w = (k == 0) ? cw(1'b1, 14'h1234) : cw(1'b1, ADDR_ERR_STATUS) ^ {15'h0000, k == 2};
            n = (k == 1) ? 15 : ((k == 3) ? 17 : 16);
            f = (k == 0) ? 3'h4 : ((k == 2) ? 3'h1 : 3'h2);
            frame(w, n, 16'h0000);
            frame(cw(1'b1, ADDR_ERR_STATUS), 16, aw(14'h0000, 1'b1));
            `CHK("flags", err_flags_o, f)
            frame(cw(1'b0, ADDR_CLEAR_ERR), 16, aw(st(1'b0, f), 1'b1));
            frame(cw(1'b0, ADDR_NOP), 16, aw(st(1'b0, 3'h0), 1'b0));
            `CHK("cleared", err_flags_o, 3'h0)
        end
    endtask
    task automatic pulse_done();
        meas_done_i = 1'b1;
        @(posedge clk);
        #1 meas_done_i = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_angle();
        frame(cw(1'b1, ADDR_ANGLE), 16, 16'h0000);
        `CHK("busy", meas_busy_o, 1'b1)
        frame(cw(1'b1, ADDR_ERR_STATUS), 16, aw({2'b11, 12'h5a5}, 1'b0));
        frame(cw(1'b0, ADDR_NOP), 16, aw(st(1'b1, 3'h0), 1'b0));
        pulse_done();
        `CHK("idle", meas_busy_o, 1'b0)
        `CHK("starts", n_start, 1)
    endtask
    task automatic t_deadlock();
        frame(cw(1'b1, ADDR_ANGLE), 16, 16'h0000);
        // Core never reports done, so the host recovers with a full reset
        frame(cw(1'b1, ADDR_MASTER_RST), 16, aw({2'b11, 12'h5a5}, 1'b0));
        `CHK("released", meas_busy_o, 1'b0)
        `CHK("resets", n_chip, 1)
        frame(cw(1'b0, ADDR_NOP), 16, 16'h0000);
        `CHK("starts", n_start, 2)
    endtask
    task automatic t_alarm();
        frame(cw(1'b1, ADDR_ANGLE), 16, 16'h0000);
        // A done report while the enable is low must not be seen
        ce = 1'b0;
        pulse_done();
        `CHK("frozen", meas_busy_o, 1'b1)
        ce = 1'b1;
        pulse_done();
        `CHK("done", meas_busy_o, 1'b0)
        frame(cw(1'b1, ADDR_ANGLE), 16, aw({2'b01, 12'h5a5}, 1'b0));
        major_err_i = 1'b1;
        pulse_done();
        frame(cw(1'b0, ADDR_NOP), 16, aw({2'b11, 12'h5a5}, 1'b0));
        major_err_i = 1'b0;
        `CHK("starts", n_start, 4)
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        t_status();
        t_errors();
        t_angle();
        t_deadlock();
        t_alarm();
        report_and_stop();
    end
    initial
    begin
        #500000;
        n_errors++;
        report_and_stop();
    end
endmodule
